/* File: hw/hsc_pkg.sv */
package hsc_pkg;

   // ******************************************************************
   // Register map.
   // ******************************************************************
   localparam int ADDR_W = 16;
   localparam logic [15:0] ADDR_CLOCK_MODE = 16'h4EE8;
   localparam logic [15:0] ADDR_SYNC_MASK = 16'hC030;
   localparam logic [15:0] ADDR_COMMAND = 16'h0064;
   localparam logic [15:0] ADDR_RATE = 16'h0100;
   localparam logic [15:0] ADDR_STATUS = 16'h0104;

   // ******************************************************************
   // Command bits of the card_command register.
   // ******************************************************************
   localparam int CMD_BIT_RESET = 0;
   localparam int CMD_BIT_SETUP = 1;
   localparam int CMD_BIT_START = 2;
   localparam int CMD_BIT_ARM = 3;
   localparam int CMD_BIT_FORCE = 4;
   localparam int CMD_BIT_DISARM = 5;
   localparam int CMD_BIT_STOP = 6;
   localparam int CMD_BIT_WAIT = 14;
   localparam int PEND_W = 8;
   localparam int PEND_WAIT = 7;

   // Codes sent to the member cards, same values as the command bits.
   localparam logic [7:0] MCODE_NONE = 8'h00;
   localparam logic [7:0] MCODE_RESET = 8'h01;
   localparam logic [7:0] MCODE_SETUP = 8'h02;
   localparam logic [7:0] MCODE_START = 8'h04;
   localparam logic [7:0] MCODE_STOP = 8'h40;

   // ******************************************************************
   // Field values, reset values and status layout.
   // ******************************************************************
   localparam logic [31:0] CLK_MODE_HUB_DIRECT = 32'h0000_0080;
   localparam logic [31:0] CLK_MODE_RST = 32'h0000_0001;
   localparam logic [31:0] SYNC_MASK_RST = 32'h0000_0001;
   localparam logic [15:0] RATE_DIV_RST = 16'h0001;
   localparam logic [15:0] RATE_DIV_MIN = 16'h0001;
   localparam int ST_BIT_RUNNING = 0;
   localparam int ST_BIT_ARMED = 1;
   localparam int ST_BIT_DIRTY = 2;
   localparam int ST_BIT_BUSY = 3;
   localparam int ST_BIT_WAITING = 4;
   localparam int ST_BIT_SETUP_ERR = 5;
   localparam int ST_BIT_CFG_REFUSED = 6;
   localparam int ST_BIT_DIRECT = 7;

   // Run state of the group.
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RUN = 2'b10
   } hsc_run_e;

endpackage

/* File: hw/hsc_member_fanout.sv */
`timescale 1ns/10ps
module hsc_member_fanout #(
   parameter int N_MEMBERS = 16,
   parameter int HUB_IDX = 0
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [N_MEMBERS-1:0] mask,
   input wire logic strobe,
   input wire logic [7:0] code,
   input wire logic [N_MEMBERS-1:0] ready_pin,
   output logic [7:0] code_out,
   output logic [N_MEMBERS-1:0] valid_out,
   output logic group_ok
);
   import hsc_pkg::*;

   logic [N_MEMBERS-1:0] ready_meta;
   logic [N_MEMBERS-1:0] ready_sync;
   logic [N_MEMBERS-1:0] next_valid;
   logic [7:0] next_code;

   // ******************************************************************
   // Per member: ready synchroniser and gated command strobe.
   // ******************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < N_MEMBERS; gi++)
      begin : g_member
         // Only members selected in the mask receive the command.
         always_comb
         begin
            next_valid[gi] = strobe & mask[gi];
         end

         // Two stages before the ready level is used.
         always_ff @(posedge clk)
         begin
            if (!rst_n)
            begin
               ready_meta[gi] <= 1'b0;
               ready_sync[gi] <= 1'b0;
               valid_out[gi] <= 1'b0;
            end
            else
            begin
               ready_meta[gi] <= ready_pin[gi];
               ready_sync[gi] <= ready_meta[gi];
               valid_out[gi] <= next_valid[gi];
            end
         end
      end
   endgenerate

   // Code is held stable between strobes.
   always_comb
   begin
      next_code = strobe ? code : code_out;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         code_out <= MCODE_NONE;
         group_ok <= 1'b0;
      end
      else
      begin
         code_out <= next_code;
         // Group is sound when the carrier is masked and every masked member is ready.
         group_ok <= mask[HUB_IDX] & (&(ready_sync | ~mask));
      end
   end

endmodule

/* File: hw/hsc_dispatch.sv */
// Operation
// - A reset command fully resets the card and all its run state.
// - Apply-setup loads pending configuration into hardware without starting a run.
// - Start first loads changed configuration, then starts the run.
// - Configuration writes are refused while a run is active.
// - Trigger-arm enables detection, with start or in a later write.
// - Force command produces an immediate trigger event during a run.
// - Disarm disables detection; trigger input edges are ignored until re-armed, force still fires.
// - Every start begins with trigger detection disabled.
// - Stop ends the current run; without a run it changes nothing.
// - Hub checks group setup and forwards commands to all masked members in order.
// - Wait completes when the carrier card reaches the state, regardless of others.
// - Clock mode value 128 selects the hub clock as external sample clock.
// - Requested divided rate is adjusted to the nearest achievable value.
// - Sync member mask holds one bit per member; only set bits join runs.
`timescale 1ns/10ps
module hsc_dispatch #(
   parameter int N_MEMBERS = 16,
   parameter int HUB_IDX = 0,
   parameter logic [15:0] RATE_DIV_MAX = 16'h0400
) (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [hsc_pkg::ADDR_W-1:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   output logic [31:0] REG_RDATA,
   input wire logic TRIG_IN,
   input wire logic RUN_DONE,
   input wire logic [N_MEMBERS-1:0] MEMBER_READY,
   output logic [7:0] MEMBER_CMD_CODE,
   output logic [N_MEMBERS-1:0] MEMBER_CMD_VALID,
   output logic CMD_BUSY,
   output logic RUNNING,
   output logic TRIG_ARMED,
   output logic TRIG_EVENT,
   output logic WAIT_DONE,
   output logic SAMPLE_CLK_DIRECT,
   output logic [15:0] SAMPLE_DIV
);
   import hsc_pkg::*;

   hsc_run_e state, next_state;
   logic [PEND_W-1:0] pend, next_pend;
   logic armed, next_armed;
   logic dirty, next_dirty;
   logic waiting, next_waiting;
   logic setup_err, next_setup_err;
   logic cfg_refused, next_cfg_refused;
   logic [31:0] clk_mode, next_clk_mode;
   logic [N_MEMBERS-1:0] sync_mask, next_sync_mask;
   logic [15:0] rate_div, next_rate_div;
   logic [31:0] next_rdata;
   logic next_trig_event, next_wait_done;
   logic fan_strobe, group_ok;
   logic [7:0] fan_code;
   logic trig_meta, trig_sync, trig_prev;
   logic running, cmd_wr, cfg_wr;
   logic [31:0] status_word;

   assign running = (state == ST_RUN);
   assign cmd_wr = REG_WR && (REG_ADDR == ADDR_COMMAND);
   assign cfg_wr = REG_WR && ((REG_ADDR == ADDR_CLOCK_MODE) || (REG_ADDR == ADDR_SYNC_MASK)
                              || (REG_ADDR == ADDR_RATE));

   // ******************************************************************
   // Member fan-out.
   // ******************************************************************
   // Forwards each group command to the masked members and checks readiness.
   hsc_member_fanout #(
      .N_MEMBERS(N_MEMBERS),
      .HUB_IDX(HUB_IDX)
   ) u_fanout (
      .clk(CORE_CLK),
      .rst_n(RST_N),
      .mask(sync_mask),
      .strobe(fan_strobe),
      .code(fan_code),
      .ready_pin(MEMBER_READY),
      .code_out(MEMBER_CMD_CODE),
      .valid_out(MEMBER_CMD_VALID),
      .group_ok(group_ok)
   );

   // Status word shown on reads of the status register.
   always_comb
   begin
      status_word = 32'h0000_0000;
      status_word[ST_BIT_RUNNING] = running;
      status_word[ST_BIT_ARMED] = armed;
      status_word[ST_BIT_DIRTY] = dirty;
      status_word[ST_BIT_BUSY] = |pend;
      status_word[ST_BIT_WAITING] = waiting;
      status_word[ST_BIT_SETUP_ERR] = setup_err;
      status_word[ST_BIT_CFG_REFUSED] = cfg_refused;
      status_word[ST_BIT_DIRECT] = SAMPLE_CLK_DIRECT;
   end

   // ******************************************************************
   // Command sequencer and register file.
   // ******************************************************************
   // Pending command bits are executed one per cycle in fixed order.
   always_comb
   begin
      next_state = state;
      next_pend = pend;
      next_armed = armed;
      next_dirty = dirty;
      next_waiting = waiting;
      next_setup_err = setup_err;
      next_cfg_refused = cfg_refused;
      next_clk_mode = clk_mode;
      next_sync_mask = sync_mask;
      next_rate_div = rate_div;
      next_trig_event = 1'b0;
      next_wait_done = 1'b0;
      fan_strobe = 1'b0;
      fan_code = MCODE_NONE;
      next_rdata = 32'h0000_0000;

      // Register reads; unmapped and write-only addresses read zero.
      if (REG_RD)
      begin
         case (REG_ADDR)
            ADDR_CLOCK_MODE: next_rdata = clk_mode;
            ADDR_SYNC_MASK: next_rdata = 32'(sync_mask);
            ADDR_RATE: next_rdata = {16'h0000, rate_div};
            ADDR_STATUS: next_rdata = status_word;
            default: next_rdata = 32'h0000_0000;
         endcase
      end

      // Setup error and refusal flags clear on writing one; a new event below wins.
      if (REG_WR && (REG_ADDR == ADDR_STATUS))
      begin
         if (REG_WDATA[ST_BIT_SETUP_ERR])
            next_setup_err = 1'b0;
         if (REG_WDATA[ST_BIT_CFG_REFUSED])
            next_cfg_refused = 1'b0;
      end

      if (cfg_wr && running)
         next_cfg_refused = 1'b1;
      else if (cfg_wr)
      begin
         next_dirty = 1'b1;
         case (REG_ADDR)
            ADDR_CLOCK_MODE: next_clk_mode = REG_WDATA;
            ADDR_SYNC_MASK: next_sync_mask = REG_WDATA[N_MEMBERS-1:0];
            default:
            begin
               if (REG_WDATA[31:16] != 16'h0000 || REG_WDATA[15:0] > RATE_DIV_MAX)
                  next_rate_div = RATE_DIV_MAX;
               else if (REG_WDATA[15:0] < RATE_DIV_MIN)
                  next_rate_div = RATE_DIV_MIN;
               else
                  next_rate_div = REG_WDATA[15:0];
            end
         endcase
      end

      // A command write is latched only while no earlier one is pending.
      if (cmd_wr && (pend == '0))
         next_pend = {REG_WDATA[CMD_BIT_WAIT], REG_WDATA[CMD_BIT_STOP:CMD_BIT_RESET]};

      if (pend[CMD_BIT_RESET])
      begin
         next_state = ST_IDLE;
         next_pend = '0;
         next_armed = 1'b0;
         next_dirty = 1'b1;
         next_waiting = 1'b0;
         next_setup_err = 1'b0;
         next_cfg_refused = 1'b0;
         next_clk_mode = CLK_MODE_RST;
         next_sync_mask = SYNC_MASK_RST[N_MEMBERS-1:0];
         next_rate_div = RATE_DIV_RST;
         fan_strobe = 1'b1;
         fan_code = MCODE_RESET;
      end
      else if (pend[CMD_BIT_SETUP])
      begin
         next_pend[CMD_BIT_SETUP] = 1'b0;
         if (!running)
         begin
            next_dirty = cfg_wr;
            fan_strobe = 1'b1;
            fan_code = MCODE_SETUP;
         end
      end
      else if (pend[CMD_BIT_START])
      begin
         if (running)
            next_pend[CMD_BIT_START] = 1'b0;
         else if (!group_ok || !sync_mask[HUB_IDX])
         begin
            next_pend[CMD_BIT_START] = 1'b0;
            next_setup_err = 1'b1;
         end
         else if (dirty)
         begin
            next_dirty = cfg_wr;
            fan_strobe = 1'b1;
            fan_code = MCODE_SETUP;
         end
         else
         begin
            next_pend[CMD_BIT_START] = 1'b0;
            next_state = ST_RUN;
            next_armed = 1'b0;
            fan_strobe = 1'b1;
            fan_code = MCODE_START;
         end
      end
      else if (pend[CMD_BIT_ARM])
      begin
         next_pend[CMD_BIT_ARM] = 1'b0;
         next_armed = running;
      end
      else if (pend[CMD_BIT_FORCE])
      begin
         next_pend[CMD_BIT_FORCE] = 1'b0;
         next_trig_event = running;
      end
      else if (pend[CMD_BIT_DISARM])
      begin
         next_pend[CMD_BIT_DISARM] = 1'b0;
         next_armed = 1'b0;
      end
      else if (pend[CMD_BIT_STOP])
      begin
         next_pend[CMD_BIT_STOP] = 1'b0;
         if (running)
         begin
            next_state = ST_IDLE;
            next_armed = 1'b0;
            fan_strobe = 1'b1;
            fan_code = MCODE_STOP;
         end
      end
      else if (pend[PEND_WAIT])
      begin
         next_pend[PEND_WAIT] = 1'b0;
         next_waiting = running;
         next_wait_done = !running;
      end

      if (running && armed && trig_sync && !trig_prev)
         next_trig_event = 1'b1;

      if (running && RUN_DONE && !pend[CMD_BIT_RESET] && !pend[CMD_BIT_STOP])
      begin
         next_state = ST_IDLE;
         next_armed = 1'b0;
         next_waiting = 1'b0;
         next_wait_done = waiting;
      end
   end

   // Registers of the sequencer, the register file, the trigger synchroniser and the outputs.
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_N)
      begin
         state <= ST_IDLE;
         pend <= '0;
         armed <= 1'b0;
         dirty <= 1'b1;
         waiting <= 1'b0;
         setup_err <= 1'b0;
         cfg_refused <= 1'b0;
         clk_mode <= CLK_MODE_RST;
         sync_mask <= SYNC_MASK_RST[N_MEMBERS-1:0];
         rate_div <= RATE_DIV_RST;
         REG_RDATA <= 32'h0000_0000;
         TRIG_EVENT <= 1'b0;
         WAIT_DONE <= 1'b0;
         trig_meta <= 1'b0;
         trig_sync <= 1'b0;
         trig_prev <= 1'b0;
         CMD_BUSY <= 1'b0;
         RUNNING <= 1'b0;
         TRIG_ARMED <= 1'b0;
         SAMPLE_CLK_DIRECT <= 1'b0;
         SAMPLE_DIV <= RATE_DIV_RST;
      end
      else
      begin
         state <= next_state;
         pend <= next_pend;
         armed <= next_armed;
         dirty <= next_dirty;
         waiting <= next_waiting;
         setup_err <= next_setup_err;
         cfg_refused <= next_cfg_refused;
         clk_mode <= next_clk_mode;
         sync_mask <= next_sync_mask;
         rate_div <= next_rate_div;
         REG_RDATA <= next_rdata;
         TRIG_EVENT <= next_trig_event;
         WAIT_DONE <= next_wait_done;
         trig_meta <= TRIG_IN;
         trig_sync <= trig_meta;
         trig_prev <= trig_sync;
         CMD_BUSY <= |next_pend;
         RUNNING <= (next_state == ST_RUN);
         TRIG_ARMED <= next_armed;
         SAMPLE_CLK_DIRECT <= (next_clk_mode == CLK_MODE_HUB_DIRECT);
         SAMPLE_DIV <= next_rate_div;
      end
   end

endmodule

/* File: bench/hsc_dispatch_checker.sv */
`timescale 1ns/10ps
module hsc_dispatch_checker
   import hsc_pkg::*;
#(
   parameter int N_MEMBERS = 16,
   parameter int HUB_IDX = 0,
   parameter logic [15:0] RATE_DIV_MAX = 16'h0400
) (
   input wire logic CORE_CLK,
   input wire logic RST_N,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [hsc_pkg::ADDR_W-1:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic [31:0] REG_RDATA,
   input wire logic RUN_DONE,
   input wire logic [7:0] MEMBER_CMD_CODE,
   input wire logic [N_MEMBERS-1:0] MEMBER_CMD_VALID,
   input wire logic CMD_BUSY,
   input wire logic RUNNING,
   input wire logic TRIG_ARMED,
   input wire logic TRIG_EVENT,
   input wire logic WAIT_DONE,
   input wire logic SAMPLE_CLK_DIRECT,
   input wire logic [15:0] SAMPLE_DIV
);
   // ****************************************************************
   // Run, trigger and register relations.
   // ****************************************************************
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);

   a_start_code: assert property (
      $rose(RUNNING) |-> MEMBER_CMD_CODE == MCODE_START && MEMBER_CMD_VALID[HUB_IDX])
      else $error("run began without a start code to the carrier");
   a_start_disarmed: assert property ($rose(RUNNING) |-> !TRIG_ARMED)
      else $error("run began with trigger detection enabled");
   a_arm_in_run: assert property (TRIG_ARMED |-> RUNNING)
      else $error("trigger armed outside a run");
   a_event_in_run: assert property (TRIG_EVENT |-> $past(RUNNING))
      else $error("trigger event outside a run");
   a_cmd_busy: assert property (
      REG_WR && REG_ADDR == ADDR_COMMAND && !CMD_BUSY && REG_WDATA[6:0] != 7'h00 |=> CMD_BUSY)
      else $error("command write did not raise busy");
   a_busy_bound: assert property ($rose(CMD_BUSY) |-> ##[1:300] !CMD_BUSY)
      else $error("command sequence did not finish");
   a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0000_0000)
      else $error("read data outside a read answer");
   a_direct_mode: assert property (
      REG_WR && REG_ADDR == ADDR_CLOCK_MODE && !RUNNING
      |-> ##2 SAMPLE_CLK_DIRECT == ($past(REG_WDATA, 2) == CLK_MODE_HUB_DIRECT))
      else $error("direct clock flag does not follow clock mode");
   a_div_range: assert property (SAMPLE_DIV >= RATE_DIV_MIN && SAMPLE_DIV <= RATE_DIV_MAX)
      else $error("sample divider out of range");
   a_done_ends: assert property (RUNNING && RUN_DONE |=> !RUNNING)
      else $error("run continued after carrier finished");

   // Main scenarios reached.
   c_run: cover property ($rose(RUNNING));
   c_event: cover property (TRIG_EVENT);
   c_wait: cover property (WAIT_DONE);
endmodule

/* File: bench/hsc_dispatch_tb.sv */
`timescale 1ns/10ps
module hsc_dispatch_tb;
   import hsc_pkg::*;
   localparam logic [15:0] DIV_MAX = 16'h0400;
   logic core_clk, rst_n, reg_wr, reg_rd, trig_in, run_done;
   logic [ADDR_W-1:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [15:0] member_ready, member_cmd_valid, sample_div;
   logic [7:0] member_cmd_code;
   logic cmd_busy, running, trig_armed, trig_event, wait_done, sample_clk_direct;
   int n_errors, tests_run, n_ev, m_ev, n_wd, seed, m_mask, m_clk, m_div;
   bit m_run, m_arm, m_dirty;
   logic [23:0] obs_q[$];
   logic [23:0] exp_q[$];
   logic [31:0] rates[4] = '{32'h0000_0000, 32'h0000_0400, 32'h0000_0401, 32'h0001_0000};

   hsc_dispatch #(.N_MEMBERS(16), .HUB_IDX(0), .RATE_DIV_MAX(DIV_MAX)) DUT (
      .CORE_CLK(core_clk), .RST_N(rst_n), .REG_WR(reg_wr), .REG_RD(reg_rd),
      .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
      .TRIG_IN(trig_in), .RUN_DONE(run_done), .MEMBER_READY(member_ready),
      .MEMBER_CMD_CODE(member_cmd_code), .MEMBER_CMD_VALID(member_cmd_valid),
      .CMD_BUSY(cmd_busy), .RUNNING(running), .TRIG_ARMED(trig_armed),
      .TRIG_EVENT(trig_event), .WAIT_DONE(wait_done),
      .SAMPLE_CLK_DIRECT(sample_clk_direct), .SAMPLE_DIV(sample_div));

   // Free running 200 MHz clock.
   initial
   begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   // Records forwarded commands and output pulses once per cycle.
   always @(negedge core_clk)
   begin
      if (member_cmd_valid !== 16'h0000)
         obs_q.push_back({member_cmd_valid, member_cmd_code});
      if (trig_event === 1'b1)
         n_ev++;
      if (wait_done === 1'b1)
         n_wd++;
   end

   // ****************************************************************
   // Checking and bus tasks.
   // ****************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic complete_run;
      $display("errors=%0d checks=%0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(negedge core_clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge core_clk);
      reg_wr = 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, input logic [31:0] e);
      @(negedge core_clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge core_clk);
      reg_rd = 1'b0;
      chk(reg_rdata, e);
   endtask

   // Configuration write; the model drops it while a run is active.
   task automatic cfg(input logic [15:0] a, input logic [31:0] d);
      wr(a, d);
      if (!m_run)
      begin
         m_dirty = 1;
         if (a == ADDR_CLOCK_MODE)
            m_clk = d;
         if (a == ADDR_SYNC_MASK)
            m_mask = d & 32'h0000_ffff;
         if (a == ADDR_RATE)
            m_div = (d[31:16] != 0 || d[15:0] > DIV_MAX) ? DIV_MAX : (d[15:0] == 0 ? 1 : d[15:0]);
      end
      repeat (3) @(negedge core_clk);
   endtask

   // Waits for the sequence to end, then compares forwards and levels.
   task automatic settle;
      int i;
      for (i = 0; i < 400 && cmd_busy !== 1'b0; i++)
         @(negedge core_clk);
      if (i == 400)
      begin
         n_errors++;
         complete_run();
      end
      repeat (3) @(negedge core_clk);
      chk(obs_q.size(), exp_q.size());
      foreach (exp_q[k])
         chk(obs_q[k], exp_q[k]);
      obs_q.delete();
      exp_q.delete();
      chk(running, m_run);
      chk(trig_armed, m_arm);
      chk(n_ev, m_ev);
   endtask

   // Model of one command word, bits taken in their fixed order.
   task automatic cmd(input logic [31:0] d);
      if (d[0])
      begin
         exp_q.push_back({m_mask[15:0], MCODE_RESET});
         {m_mask, m_clk, m_div, m_run, m_arm, m_dirty} = {32'd1, 32'd1, 32'd1, 3'b001};
      end
      if (d[1] && !m_run)
      begin
         exp_q.push_back({m_mask[15:0], MCODE_SETUP});
         m_dirty = 0;
      end
      if (d[2] && !m_run && m_mask[0])
      begin
         if (m_dirty)
            exp_q.push_back({m_mask[15:0], MCODE_SETUP});
         exp_q.push_back({m_mask[15:0], MCODE_START});
         {m_run, m_arm, m_dirty} = 3'b100;
      end
      if (d[3] && m_run)
         m_arm = 1;
      if (d[4] && m_run)
         m_ev++;
      if (d[5])
         m_arm = 0;
      if (d[6] && m_run)
      begin
         exp_q.push_back({m_mask[15:0], MCODE_STOP});
         {m_run, m_arm} = 2'b00;
      end
      wr(ADDR_COMMAND, d);
      settle();
   endtask

   task automatic trig;
      @(negedge core_clk);
      trig_in = 1'b1;
      if (m_run && m_arm)
         m_ev++;
      repeat (4) @(negedge core_clk);
      trig_in = 1'b0;
      repeat (6) @(negedge core_clk);
      chk(n_ev, m_ev);
   endtask

   // ****************************************************************
   // Main sequence.
   // ****************************************************************
   initial
   begin
      seed = 32'h337a2fca;
      {rst_n, reg_wr, reg_rd, trig_in, run_done, reg_addr, reg_wdata} = '0;
      member_ready = 16'hffff;
      {m_mask, m_clk, m_div, m_dirty} = {32'd1, 32'd1, 32'd1, 1'b1};
      repeat (3) @(negedge core_clk);
      rst_n = 1'b1;
      rd(ADDR_CLOCK_MODE, CLK_MODE_RST);
      rd(ADDR_SYNC_MASK, SYNC_MASK_RST);
      rd(ADDR_COMMAND, 32'h0000_0000);
      rd(16'h0200, 32'h0000_0000);
      repeat (4)
      begin
         cfg(ADDR_RATE, $random(seed) & 32'h0000_07ff);
         chk(sample_div, m_div);
      end
      foreach (rates[i])
      begin
         cfg(ADDR_RATE, rates[i]);
         chk(sample_div, m_div);
      end
      cmd(32'h0000_0040);
      cfg(ADDR_SYNC_MASK, 32'h0000_0002);
      cmd(32'h0000_0004);
      // Refused start leaves the setup error flag beside the dirty flag.
      rd(ADDR_STATUS, (32'h0000_0001 << ST_BIT_SETUP_ERR) | (32'h0000_0001 << ST_BIT_DIRTY));
      cfg(ADDR_SYNC_MASK, 32'h0000_000b);
      cmd(32'h0000_000c);
      trig();
      cfg(ADDR_CLOCK_MODE, CLK_MODE_HUB_DIRECT);
      rd(ADDR_CLOCK_MODE, m_clk);
      // Running, armed, the earlier setup error and the new refusal flag are set.
      rd(ADDR_STATUS, 32'h0000_0063);
      cmd(32'h0000_0004);
      cmd(32'h0000_0020);
      trig();
      cmd(32'h0000_0010);
      cmd(32'h0000_0040);
      cmd(32'h0000_0008);
      cfg(ADDR_CLOCK_MODE, CLK_MODE_HUB_DIRECT);
      chk(sample_clk_direct, 1'b1);
      cmd(32'h0000_0004);
      cmd(32'h0000_0008);
      wr(ADDR_COMMAND, 32'h0000_4000);
      {m_run, m_arm} = 2'b00;
      repeat (5) @(negedge core_clk);
      run_done = 1'b1;
      @(negedge core_clk);
      run_done = 1'b0;
      settle();
      chk(n_wd, 1);
      cmd(32'h0000_0002);
      cmd(32'h0000_0001);
      rd(ADDR_CLOCK_MODE, CLK_MODE_RST);
      rd(ADDR_SYNC_MASK, SYNC_MASK_RST);
      complete_run();
   end
endmodule

bind hsc_dispatch hsc_dispatch_checker #(.N_MEMBERS(N_MEMBERS), .HUB_IDX(HUB_IDX), .RATE_DIV_MAX(RATE_DIV_MAX))
   u_chk (.CORE_CLK, .RST_N, .REG_WR, .REG_RD, .REG_ADDR, .REG_WDATA, .REG_RDATA, .RUN_DONE,
   .MEMBER_CMD_CODE, .MEMBER_CMD_VALID, .CMD_BUSY, .RUNNING, .TRIG_ARMED, .TRIG_EVENT,
   .WAIT_DONE, .SAMPLE_CLK_DIRECT, .SAMPLE_DIV);
